// File: design/burst_addr_gen.sv
// Burst sequence generator for the low address bits
`timescale 1ns/10ps
module burst_addr_gen #(
  parameter int BURST_W = sram_pkg::BURST_W
) (
  input wire logic [BURST_W-1:0] start,
  input wire logic [BURST_W-1:0] step,
  input wire logic interleave,
  output logic [BURST_W-1:0] lsb
);
  // Linear wraps inside the burst, interleaved flips bits of the start
  assign lsb = interleave ? (start ^ step) : BURST_W'(start + step);
endmodule

// File: design/burst_sram_core.sv
// Pipelined burst SRAM core with zero-turnaround read/write pipeline
`timescale 1ns/10ps

// How it works
// - All synchronous pins are caught in input registers at each qualified rising edge.
// - Read data leaves through output registers loaded on the rising edge.
// - With clock qualify deasserted every pipeline and output register holds.
// - Writes need the write strobe; only lanes with active byte selects change.
// - Array is 2M x 36, 4M x 18 or 1M x 72 by parameters.
// - A cycle is selected only when all three chip selects are active.
// - Output enable pin turns the data drivers off at once, without the clock.
// - Drivers are switched off synchronously in the data slot of a write.
// - Reads and writes mix back to back with no idle cycles.
// - Writes finish in an internal write engine; no host timing needed.
// - Burst strap low gives linear burst order.
// - Burst strap high or floating gives interleaved burst order.
// - Sleep pin stops commands and the array; stopped clock keeps all state.
// - Boundary-scan test port of the published standard, outside this core.
// - One-word-per-cycle pipeline with no multi-cycle paths for top speed.
module burst_sram_core #(
  parameter int DATA_W = sram_pkg::DATA_W,
  parameter int ADDR_W = sram_pkg::ADDR_W,
  parameter int LANES = sram_pkg::LANES,
  parameter int BURST_W = sram_pkg::BURST_W,
  parameter int FIFO_DEPTH = sram_pkg::FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic burst_advance,
  input wire logic write_strobe_n,
  input wire logic [LANES-1:0] byte_lane_write_sel_n,
  input wire logic chip_select_1_n,
  input wire logic chip_select_2,
  input wire logic chip_select_3_n,
  input wire logic clock_qualify_n,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic burst_order_strap,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe
);
  import sram_pkg::*;

  localparam int LANE_W = DATA_W / LANES;
  localparam int PAY_W = ADDR_W + LANES + DATA_W;
  localparam int WORDS = 2 ** ADDR_W;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [SYNC_STAGES-1:0] sleep_sync_q;
  logic [SYNC_STAGES-1:0] strap_sync_q;
  logic sleep_q;
  logic interleave_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sleep_sync_q <= {SYNC_STAGES{SLEEP_RST}};
    end else begin
      sleep_sync_q <= {sleep_sync_q[SYNC_STAGES-2:0], sleep_request};
    end
  end

  // Chain starts at the reset order, so no linear window follows reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      strap_sync_q <= {SYNC_STAGES{INTERLEAVE_RST}};
    end else begin
      strap_sync_q <= {strap_sync_q[SYNC_STAGES-2:0], burst_order_strap};
    end
  end

  // A change only counts once the last two stages agree
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sleep_q <= SLEEP_RST;
    end else if (sleep_sync_q[1] == sleep_sync_q[2]) begin
      sleep_q <= sleep_sync_q[2];
    end
  end

  // Strap is expected static; until it settles, interleaved order is assumed
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      interleave_q <= INTERLEAVE_RST;
    end else if (strap_sync_q[1] == strap_sync_q[2]) begin
      interleave_q <= strap_sync_q[2];
    end
  end

  // ****************************************
  // Input registers
  // ****************************************
  logic qual;
  logic [ADDR_W-1:0] in_addr_q;
  logic in_adv_q;
  logic in_we_n_q;
  logic [LANES-1:0] in_sel_n_q;
  logic [2:0] in_cs_q;

  assign qual = !clock_qualify_n;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      in_addr_q <= '0;
    end else if (qual) begin
      in_addr_q <= addr;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      in_adv_q <= 1'h0;
      in_we_n_q <= 1'h1;
    end else if (qual) begin
      in_adv_q <= burst_advance;
      in_we_n_q <= write_strobe_n;
    end
  end

  // Reset to all lanes off and the bank deselected
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      in_sel_n_q <= '1;
      in_cs_q <= 3'h5;
    end else if (qual) begin
      in_sel_n_q <= byte_lane_write_sel_n;
      in_cs_q <= {chip_select_3_n, chip_select_2, chip_select_1_n};
    end
  end

  // ****************************************
  // Command decode and burst tracking
  // ****************************************
  stream_if #(.WIDTH(PAY_W)) wr_push ();
  stream_if #(.WIDTH(PAY_W)) wr_pop ();

  logic selected;
  logic cmd_ok;
  logic drain_pend_q;
  op_t load_op;
  op_t next_op;
  op_t burst_op_q;
  op_t s2_op_q;
  logic [ADDR_W-1:0] base_q;
  logic [BURST_W-1:0] cnt_q;
  logic [BURST_W-1:0] next_cnt;
  logic [BURST_W-1:0] burst_lsb;
  logic [ADDR_W-1:0] next_addr;
  logic [ADDR_W-1:0] s2_addr_q;
  logic [LANES-1:0] s2_mask_q;

  assign selected = !in_cs_q[0] && in_cs_q[1] && !in_cs_q[2];
  // Commands are dropped while asleep or while writes held over sleep still drain
  assign cmd_ok = !sleep_q && !drain_pend_q && wr_push.ready;
  assign next_cnt = BURST_W'(cnt_q + 1'b1);

  burst_addr_gen #(
    .BURST_W(BURST_W)
  ) u_burst (
    .start(base_q[BURST_W-1:0]),
    .step(next_cnt),
    .interleave(interleave_q),
    .lsb(burst_lsb)
  );

  always_comb begin
    load_op = OP_IDLE;
    if (selected && cmd_ok) begin
      load_op = in_we_n_q ? OP_READ : OP_WRITE;
    end
    if (!in_adv_q) begin
      next_op = load_op;
      next_addr = in_addr_q;
    end else begin
      next_op = cmd_ok ? burst_op_q : OP_IDLE;
      next_addr = {base_q[ADDR_W-1:BURST_W], burst_lsb};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      base_q <= '0;
    end else if (qual && !in_adv_q) begin
      base_q <= in_addr_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (qual && !in_adv_q) begin
      cnt_q <= '0;
    end else if (qual) begin
      cnt_q <= next_cnt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      burst_op_q <= OP_IDLE;
    end else if (qual && !in_adv_q) begin
      burst_op_q <= load_op;
    end
  end

  // Second stage: one command per edge, so any read/write mix streams
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s2_op_q <= OP_IDLE;
      s2_addr_q <= '0;
      s2_mask_q <= '0;
    end else if (qual) begin
      s2_op_q <= next_op;
      s2_addr_q <= next_addr;
      s2_mask_q <= ~in_sel_n_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      drain_pend_q <= 1'h0;
    end else if (sleep_q) begin
      drain_pend_q <= 1'h1;
    end else if (!wr_pop.valid) begin
      drain_pend_q <= 1'h0;
    end
  end

  // ****************************************
  // Write buffer and self-timed write engine
  // ****************************************
  logic [DATA_W-1:0] mem [WORDS];
  logic [ADDR_W-1:0] head_addr;
  logic [LANES-1:0] head_mask;
  logic [DATA_W-1:0] head_data;
  logic commit;

  // Buffer entry is the input register for write data in its slot
  assign wr_push.valid = qual && (s2_op_q == OP_WRITE);
  assign wr_push.data = {s2_addr_q, s2_mask_q, dq_in};
  // Array sleeps with the pins; held writes resume on wake
  assign wr_pop.ready = qual && !sleep_q;
  assign {head_addr, head_mask, head_data} = wr_pop.data;
  assign commit = wr_pop.valid && wr_pop.ready;

  stream_fifo #(
    .WIDTH(PAY_W),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .push(wr_push),
    .pop(wr_pop)
  );

  // Array write fired from the buffer head; no pulse from the host
  always_ff @(posedge sys_clk) begin
    if (commit) begin
      for (int i = 0; i < LANES; i++) begin
        if (head_mask[i]) begin
          mem[head_addr][i*LANE_W +: LANE_W] <= head_data[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  // ****************************************
  // Read path and output drivers
  // ****************************************
  logic [DATA_W-1:0] rd_word;
  logic [DATA_W-1:0] dq_out_q;
  logic drive_q;

  // A write one command older still sits at the buffer head; forward it
  always_comb begin
    rd_word = mem[s2_addr_q];
    if (commit && (head_addr == s2_addr_q)) begin
      for (int i = 0; i < LANES; i++) begin
        if (head_mask[i]) begin
          rd_word[i*LANE_W +: LANE_W] = head_data[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dq_out_q <= '0;
    end else if (qual && (s2_op_q == OP_READ)) begin
      dq_out_q <= rd_word;
    end
  end

  // Writes and deselects float the bus in their slot; stall keeps the last
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      drive_q <= DRIVE_RST;
    end else if (qual) begin
      drive_q <= (s2_op_q == OP_READ) && !sleep_q;
    end
  end

  assign dq_out = dq_out_q;
  // Enable pin gates the drivers with no clock in the path
  assign dq_oe = drive_q && !output_enable_n;

endmodule

// File: design/sram_pkg.sv
// Shared constants and types for the pipelined burst SRAM core
package sram_pkg;

  // ****************************************
  // Array organisations
  // ****************************************
  localparam int WORDS_X36 = 32'h0020_0000;
  localparam int WIDTH_X36 = 36;
  localparam int ADDR_W_X36 = 21;
  localparam int LANES_X36 = 4;
  localparam int WORDS_X18 = 32'h0040_0000;
  localparam int WIDTH_X18 = 18;
  localparam int ADDR_W_X18 = 22;
  localparam int LANES_X18 = 2;
  localparam int WORDS_X72 = 32'h0010_0000;
  localparam int WIDTH_X72 = 72;
  localparam int ADDR_W_X72 = 20;
  localparam int LANES_X72 = 8;

  // ****************************************
  // Defaults of the top level
  // ****************************************
  localparam int DATA_W = WIDTH_X36;
  localparam int ADDR_W = ADDR_W_X36;
  localparam int LANES = LANES_X36;
  localparam int BURST_W = 2;
  localparam int FIFO_DEPTH = 8;
  localparam int SYNC_STAGES = 3;
  localparam int CLK_PERIOD_NS = 25;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic INTERLEAVE_RST = 1'h1;
  localparam logic SLEEP_RST = 1'h0;
  localparam logic DRIVE_RST = 1'h0;

  typedef enum logic [1:0] {
    OP_IDLE,
    OP_READ,
    OP_WRITE
  } op_t;

endpackage

// File: design/stream_fifo.sv
// Word FIFO with valid/ready on both sides
`timescale 1ns/10ps
module stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = sram_pkg::FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst,
  stream_if.sink push,
  stream_if.src pop
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] FULL = CNT_W'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [CNT_W-1:0] count_q;
  logic do_push;
  logic do_pop;

  assign push.ready = (count_q != FULL);
  assign pop.valid = (count_q != '0);
  assign pop.data = mem[rd_ptr_q];
  assign do_push = push.valid && push.ready;
  assign do_pop = pop.valid && pop.ready;

  always_ff @(posedge sys_clk) begin
    if (do_push) begin
      mem[wr_ptr_q] <= push.data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_ptr_q <= '0;
    end else if (do_push) begin
      wr_ptr_q <= (wr_ptr_q == LAST) ? '0 : PTR_W'(wr_ptr_q + 1'b1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_ptr_q <= '0;
    end else if (do_pop) begin
      rd_ptr_q <= (rd_ptr_q == LAST) ? '0 : PTR_W'(rd_ptr_q + 1'b1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count_q <= '0;
    end else if (do_push && !do_pop) begin
      count_q <= CNT_W'(count_q + 1'b1);
    end else if (do_pop && !do_push) begin
      count_q <= CNT_W'(count_q - 1'b1);
    end
  end
endmodule

// File: design/stream_if.sv
// Valid/ready word stream between the core and its write buffer
`timescale 1ns/10ps
interface stream_if #(
  parameter int WIDTH = 8
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;

  modport src (
    output valid,
    output data,
    input ready
  );

  modport sink (
    input valid,
    input data,
    output ready
  );
endinterface

// File: sim/burst_sram_core_chk.sv
// Port-level assertions for the burst SRAM core
`timescale 1ns/10ps
module burst_sram_core_chk #(
  parameter int DATA_W = sram_pkg::DATA_W
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic burst_advance,
  input wire logic write_strobe_n,
  input wire logic chip_select_1_n,
  input wire logic chip_select_2,
  input wire logic chip_select_3_n,
  input wire logic clock_qualify_n,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic dq_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [4:0] awake_q;
  logic sel;
  logic cmd;
  assign sel = !chip_select_1_n && chip_select_2 && !chip_select_3_n;
  assign cmd = !clock_qualify_n && !burst_advance;
  // Reads just after a wake may be refused while buffered writes drain
  always_ff @(posedge sys_clk) begin
    if (rst || sleep_request) begin
      awake_q <= 5'h0;
    end else if (awake_q != 5'h10) begin
      awake_q <= awake_q + 5'h1;
    end
  end
  property p_desel_off; cmd && !sel ##1 !clock_qualify_n [*2] |=> !dq_oe; endproperty
  a_desel_off: assert property (p_desel_off) else $error("deselect slot drove dq");
  property p_write_off; cmd && sel && !write_strobe_n ##1 !clock_qualify_n [*2] |=> !dq_oe; endproperty
  a_write_off: assert property (p_write_off) else $error("write slot drove dq");
  property p_read_on;
    cmd && sel && write_strobe_n && awake_q == 5'h10 ##1 (!clock_qualify_n && awake_q == 5'h10) [*2]
      |=> output_enable_n || dq_oe;
  endproperty
  a_read_on: assert property (p_read_on) else $error("read slot not driven");
  property p_oe_gate; output_enable_n |-> !dq_oe; endproperty
  a_oe_gate: assert property (p_oe_gate) else $error("dq driven with output enable off");
  property p_stall_out; clock_qualify_n |=> $stable(dq_out); endproperty
  a_stall_out: assert property (p_stall_out) else $error("dq_out moved in stall");
  property p_stall_oe; clock_qualify_n ##1 $stable(output_enable_n) |-> $stable(dq_oe); endproperty
  a_stall_oe: assert property (p_stall_oe) else $error("dq_oe moved in stall");
  property p_reset; $past(rst) |-> !dq_oe && dq_out == '0; endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
  property p_out_edge; $changed(dq_out) |-> !$past(clock_qualify_n) || $past(rst); endproperty
  a_out_edge: assert property (p_out_edge) else $error("dq_out moved without qualified edge");
endmodule

// File: sim/burst_sram_core_test.sv
// Self-checking bench for the burst SRAM core
`timescale 1ns/10ps
bind burst_sram_core burst_sram_core_chk #(.DATA_W(DATA_W)) burst_sram_core_chk_i (.sys_clk(sys_clk), .rst(rst),
  .burst_advance(burst_advance), .write_strobe_n(write_strobe_n), .chip_select_1_n(chip_select_1_n),
  .chip_select_2(chip_select_2), .chip_select_3_n(chip_select_3_n), .clock_qualify_n(clock_qualify_n),
  .output_enable_n(output_enable_n), .sleep_request(sleep_request), .dq_out(dq_out), .dq_oe(dq_oe));
module burst_sram_core_test;
  import sram_pkg::*;
  localparam int LANE_W = DATA_W / LANES;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic output_enable_n = 1'b0;
  logic sleep_request = 1'b0;
  logic burst_order_strap = 1'b0;
  logic burst_advance, write_strobe_n, clock_qualify_n, dq_oe;
  logic [2:0] cs;
  logic [ADDR_W-1:0] addr;
  logic [LANES-1:0] sel_n;
  logic [DATA_W-1:0] dq_in, dq_out, ex1, ex2, exc;
  logic [DATA_W-1:0] mem [int];
  logic r1, r2, rc, slp, full;
  int bad_count = 0;
  int n_compared = 0;
  int seed = 32'h3d83_1410;
  int base, st, n, kind;
  always #12.5 sys_clk = ~sys_clk;
  sram_host_model sram_host_model_i (.addr(addr), .burst_advance(burst_advance), .write_strobe_n(write_strobe_n),
    .byte_lane_write_sel_n(sel_n), .cs(cs), .clock_qualify_n(clock_qualify_n), .dq_in(dq_in));
  burst_sram_core burst_sram_core_i (.sys_clk(sys_clk), .rst(rst), .addr(addr), .burst_advance(burst_advance),
    .write_strobe_n(write_strobe_n), .byte_lane_write_sel_n(sel_n), .chip_select_1_n(cs[2]),
    .chip_select_2(cs[1]), .chip_select_3_n(cs[0]), .clock_qualify_n(clock_qualify_n),
    .output_enable_n(output_enable_n), .sleep_request(sleep_request), .burst_order_strap(burst_order_strap),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
  task automatic check(input logic [DATA_W-1:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One bus cycle: check the slot that just closed, then present the next command
  task automatic cyc(input int op, input int a, input logic stall);
    logic adv;
    logic [LANES-1:0] s;
    logic [DATA_W-1:0] d;
    logic [2:0] c;
    @(posedge sys_clk);
    #1;
    if (!clock_qualify_n) begin
      if (r2) check(dq_out, ex2);
      check(DATA_W'(dq_oe), DATA_W'(r2 && !output_enable_n));
      {r2, ex2, r1, ex1} = {r1, ex1, rc, exc};
    end
    output_enable_n = ($random(seed) & 15) == 0;
    if (stall) begin
      sram_host_model_i.put(1'b0, 1'b1, 3'h5, '0, '0, '0, 1'b1);
      return;
    end
    d = DATA_W'({$random(seed), $random(seed)});
    s = full ? '0 : LANES'($random(seed));
    c = 3'h2;
    adv = op == 3;
    if (adv) begin
      n++;
      a = base + (burst_order_strap ? st ^ (n % 4) : (st + n) % 4);
      op = kind;
    end else begin
      base = a & ~3;
      st = a & 3;
      n = 0;
      kind = op;
      if (op == 0) c = 3'($random(seed));
      if (op == 0 && c == 3'h2) c = 3'h0;
    end
    rc = op == 1 && !slp;
    if (op == 1) exc = mem[a];
    if (op == 2) for (int i = 0; i < LANES; i++) if (!s[i]) mem[a][LANE_W*i +: LANE_W] = d[LANE_W*i +: LANE_W];
    sram_host_model_i.put(adv, op != 2, c, ADDR_W'(a), s, d, 1'b0);
  endtask
  task automatic rst_seq(input logic strap);
    rst = 1'b1;
    burst_order_strap = strap;
    {r1, r2, rc, slp} = '0;
    repeat (3) @(posedge sys_clk);
    #1 rst = 1'b0;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    full = 1'b0;
    for (int ph = 0; ph < 2; ph++) begin
      rst_seq(ph[0]);
      repeat (4) cyc(0, 0, 0);
      full = 1'b1;
      for (int a = 0; a < 16; a++) cyc(2, a, 0);
      full = 1'b0;
      cyc(2, 5, 0);
      cyc(1, 5, 0);
      cyc(1, 6, 0);
      repeat (4) cyc(3, 0, 0);
      cyc(2, 9, 0);
      repeat (3) cyc(3, 0, 0);
      cyc(1, 9, 0);
      repeat (3) cyc(3, 0, 0);
      cyc(0, 0, 0);
      cyc(3, 0, 0);
      repeat (400) cyc($unsigned($random(seed)) % 4, $unsigned($random(seed)) % 16, ($random(seed) & 7) == 0);
      sleep_request = 1'b1;
      repeat (6) cyc(0, 0, 0);
      slp = 1'b1;
      repeat (4) cyc(1, 3, 0);
      sleep_request = 1'b0;
      repeat (20) cyc(0, 0, 0);
      slp = 1'b0;
      cyc(1, 3, 0);
      repeat (3) cyc(0, 0, 0);
      $display("test %0d done, burst strap %0d", ph, ph);
    end
    give_verdict();
  end
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
endmodule

// File: sim/sram_host_model.sv
// Host controller model driving the SRAM bus pins
`timescale 1ns/10ps
module sram_host_model
  import sram_pkg::*;
(
  output logic [ADDR_W-1:0] addr,
  output logic burst_advance,
  output logic write_strobe_n,
  output logic [LANES-1:0] byte_lane_write_sel_n,
  output logic [2:0] cs,
  output logic clock_qualify_n,
  output logic [DATA_W-1:0] dq_in
);
  logic [DATA_W-1:0] d1, d2, dn;
  logic v1, v2, wn;
  initial begin
    {addr, burst_advance, write_strobe_n, byte_lane_write_sel_n, dq_in, dn} = '0;
    cs = 3'h5;
    clock_qualify_n = 1'b0;
    {v1, v2, wn} = '0;
  end
  // Idle data lines toggle so a stale word is never mistaken for real data
  task automatic put(input logic adv, we_n, input logic [2:0] c, input logic [ADDR_W-1:0] a,
    input logic [LANES-1:0] sel, input logic [DATA_W-1:0] d, input logic stall);
    if (!clock_qualify_n) begin
      {d2, v2, d1, v1} = {d1, v1, dn, wn};
      dq_in = v2 ? d2 : ~dq_in;
    end
    clock_qualify_n = stall;
    if (!stall) begin
      {addr, burst_advance, write_strobe_n, byte_lane_write_sel_n, cs} = {a, adv, we_n, sel, c};
      dn = d;
      wn = !we_n && c == 3'h2;
    end
  endtask
endmodule
